// ===== psc_params.svh
// Constants for the pack status and configuration word block
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_CMD_PACK_STATUS 8'h2F
`define PSC_CMD_CELL_A 8'h3C
`define PSC_CMD_CELL_B 8'h3D
`define PSC_CMD_CELL_C 8'h3E
`define PSC_CMD_CELL_D 8'h3F
`define PSC_FLASH_PACK_CFG_ADDR 8'h28
`define PSC_BIT_FE_FAIL 7
`define PSC_BIT_EDV_LOW 6
`define PSC_BIT_SEALED 5
`define PSC_BIT_DSG_QUAL 4
`define PSC_BIT_ZERO 3
`define PSC_BIT_SAFETY 2
`define PSC_BIT_SEC_OVER 1
`define PSC_BIT_SEC_UNDER 0
`define PSC_RESET_WORD 16'h0000
`define PSC_RESET_CFG 8'h00
`define PSC_RESET_BYTE 8'h00
`endif

// ===== psc_pkg.sv
// Types for the pack status and configuration word block
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_LOAD_REQ,
        PSC_LOAD_WAIT,
        PSC_RUN
    } psc_load_type;
endpackage

// ===== psc_status_word.sv
// Pack status word, configuration mirror and per-cell voltage reads
`include "psc_params.svh"

// Summary of operation
// - Status low byte, configuration high byte
// - Configuration byte mirrors flash pack configuration
// - Fixed status layout, bit 3 zero
// - Bit 7 shows front-end integrity failure
// - Bit 6 shows voltage at/below threshold
// - Bit 5 shows sealed state
// - Bit 4 shows discharge qualifies for update
// - Bit 2 safety flag sticky until reset
// - Bit 1 follows live over-limit faults
// - Bit 0 follows live under-limit faults
// - Four cell voltage reads in millivolts
// - Flash read at reset, written only for history
// - Read-word answers with two data bytes
module psc_status_word
    import psc_pkg::*;
#(
    parameter int CELL_WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Read-word command port from the bus engine
    input wire logic readStrobe,
    input wire logic [7:0] readCommand,
    output logic readValid,
    output logic [7:0] readLowByte,
    output logic [7:0] readHighByte,
    output logic readUnknown,
    // Configuration flash read port
    output logic flashReadReq,
    output logic [7:0] flashReadAddr,
    input wire logic flashReadDone,
    input wire logic [7:0] flashReadData,
    output logic configLoaded,
    // History save port; only path that writes the flash
    input wire logic historySave,
    output logic flashWriteEnable,
    // Live status sources
    input wire logic front_end_integrity_fail,
    input wire logic end_discharge_threshold_low,
    input wire logic sealedState,
    input wire logic discharge_qualified,
    input wire logic safety_limit_exceeded,
    input wire logic secondary_over_limit,
    input wire logic secondary_under_limit,
    // Calculated per-cell voltages in mV, cell a first
    input wire logic [CELL_WIDTH-1:0] per_cell_voltage_a,
    input wire logic [CELL_WIDTH-1:0] per_cell_voltage_b,
    input wire logic [CELL_WIDTH-1:0] per_cell_voltage_c,
    input wire logic [CELL_WIDTH-1:0] per_cell_voltage_d
);

    psc_load_type loadState;
    psc_load_type next_loadState;
    logic [7:0] packConfig;
    logic [7:0] next_packConfig;
    logic safetySticky;
    logic next_safetySticky;
    logic [15:0] answerWord;
    logic next_readValid;
    logic [7:0] next_readLowByte;
    logic [7:0] next_readHighByte;
    logic next_readUnknown;
    logic next_flashReadReq;
    logic next_configLoaded;
    logic next_flashWriteEnable;
    logic [7:0] next_flashReadAddr;
    logic [7:0] statusByte;

    // Zero-extend or trim a cell reading to the word width
    function automatic logic [15:0] cellWord(input logic [CELL_WIDTH-1:0] v);
        logic [15:0] w;
        w = '0;
        for (int i = 0; i < CELL_WIDTH && i < 16; i++) begin
            w[i] = v[i];
        end
        return w;
    endfunction

    // Assemble status byte from live sources and the sticky flag
    always_comb begin
        statusByte = 8'h00;
        statusByte[`PSC_BIT_FE_FAIL] = front_end_integrity_fail;
        statusByte[`PSC_BIT_EDV_LOW] = end_discharge_threshold_low;
        statusByte[`PSC_BIT_SEALED] = sealedState;
        statusByte[`PSC_BIT_DSG_QUAL] = discharge_qualified;
        statusByte[`PSC_BIT_ZERO] = 1'b0;
        statusByte[`PSC_BIT_SAFETY] = safetySticky | safety_limit_exceeded;
        statusByte[`PSC_BIT_SEC_OVER] = secondary_over_limit;
        statusByte[`PSC_BIT_SEC_UNDER] = secondary_under_limit;
    end

    // Configuration load from flash during reset sequence
    always_comb begin
        next_loadState = loadState;
        next_packConfig = packConfig;
        next_flashReadReq = 1'b0;
        next_configLoaded = configLoaded;
        unique case (loadState)
            PSC_LOAD_REQ: begin
                next_flashReadReq = 1'b1;
                next_loadState = PSC_LOAD_WAIT;
            end
            PSC_LOAD_WAIT: begin
                if (flashReadDone) begin
                    next_packConfig = flashReadData;
                    next_configLoaded = 1'b1;
                    next_loadState = PSC_RUN;
                end
            end
            PSC_RUN: begin
                next_loadState = PSC_RUN;
            end
        endcase
    end

    // Sticky safety flag: only reset clears it
    always_comb begin
        next_safetySticky = safetySticky | safety_limit_exceeded;
    end

    // Flash writes only accompany a history save
    always_comb begin
        next_flashWriteEnable = historySave && (loadState == PSC_RUN);
    end

    // Command decode; one registered snapshot per read keeps bytes coherent
    always_comb begin
        answerWord = 16'h0000;
        next_readUnknown = 1'b0;
        unique case (readCommand)
            `PSC_CMD_PACK_STATUS: answerWord = {packConfig, statusByte};
            `PSC_CMD_CELL_A: answerWord = cellWord(per_cell_voltage_a);
            `PSC_CMD_CELL_B: answerWord = cellWord(per_cell_voltage_b);
            `PSC_CMD_CELL_C: answerWord = cellWord(per_cell_voltage_c);
            `PSC_CMD_CELL_D: answerWord = cellWord(per_cell_voltage_d);
            default: next_readUnknown = readStrobe;
        endcase
        next_readValid = readStrobe;
        next_readLowByte = readLowByte;
        next_readHighByte = readHighByte;
        if (readStrobe) begin
            next_readLowByte = answerWord[7:0];
            next_readHighByte = answerWord[15:8];
        end
    end

    // Load sequence registers; a reset in mid-run restarts the flash read
    always_ff @(posedge clk) begin
        if (srst) begin
            loadState <= PSC_LOAD_REQ;
            packConfig <= `PSC_RESET_CFG;
            flashReadReq <= 1'b0;
            configLoaded <= 1'b0;
        end else begin
            loadState <= next_loadState;
            packConfig <= next_packConfig;
            flashReadReq <= next_flashReadReq;
            configLoaded <= next_configLoaded;
        end
    end

    // Sticky safety register; nothing but reset clears it
    always_ff @(posedge clk) begin
        if (srst) begin
            safetySticky <= 1'b0;
        end else begin
            safetySticky <= next_safetySticky;
        end
    end

    // Read answer registers; both bytes load at one edge
    always_ff @(posedge clk) begin
        if (srst) begin
            readValid <= 1'b0;
            readLowByte <= `PSC_RESET_BYTE;
            readHighByte <= `PSC_RESET_BYTE;
            readUnknown <= 1'b0;
        end else begin
            readValid <= next_readValid;
            readLowByte <= next_readLowByte;
            readHighByte <= next_readHighByte;
            readUnknown <= next_readUnknown;
        end
    end

    // Flash write enable register; held low through reset
    always_ff @(posedge clk) begin
        if (srst) begin
            flashWriteEnable <= 1'b0;
        end else begin
            flashWriteEnable <= next_flashWriteEnable;
        end
    end

    // Flash address is fixed: only the pack configuration byte is needed
    always_comb begin
        next_flashReadAddr = `PSC_FLASH_PACK_CFG_ADDR;
    end

    // Address register; no reset, settles at the first edge
    always_ff @(posedge clk) begin
        flashReadAddr <= next_flashReadAddr;
    end

endmodule

// ===== psc_status_word_asserts.sv
// Checker for the status word read port and flash access
module psc_status_word_asserts #(
    parameter int CELL_WIDTH = 16
) (
    // Clock, reset, read port
    input wire logic clk,
    input wire logic srst,
    input wire logic readStrobe,
    input wire logic [7:0] readCommand,
    input wire logic readValid,
    input wire logic [7:0] readLowByte,
    input wire logic [7:0] readHighByte,
    // Flash access and live sources
    input wire logic flashReadReq,
    input wire logic [7:0] flashReadAddr,
    input wire logic historySave,
    input wire logic flashWriteEnable,
    input wire logic front_end_integrity_fail,
    input wire logic end_discharge_threshold_low,
    input wire logic sealedState,
    input wire logic discharge_qualified,
    input wire logic safety_limit_exceeded,
    input wire logic secondary_over_limit,
    input wire logic secondary_under_limit,
    input wire logic [CELL_WIDTH-1:0] per_cell_voltage_a
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Status read taken at this edge
    logic st;
    assign st = readStrobe && readCommand == 8'h2F;
    AST_ANSWER: assert property (readStrobe |=> readValid)
        else $error("read not answered");
    AST_QUIET: assert property (!readStrobe |=> !readValid)
        else $error("answer without request");
    AST_LOWBITS: assert property (st |=> !readLowByte[3] &&
        readLowByte[1:0] == {$past(secondary_over_limit), $past(secondary_under_limit)})
        else $error("bad low status bits");
    AST_HIGHBITS: assert property (st |=> readLowByte[7:4] ==
        {$past(front_end_integrity_fail), $past(end_discharge_threshold_low),
        $past(sealedState), $past(discharge_qualified)}) else $error("bad upper status");
    AST_SAFETY: assert property (st && safety_limit_exceeded |=> readLowByte[2])
        else $error("safety bit missing");
    AST_CELL: assert property (readStrobe && readCommand == 8'h3C |=>
        {readHighByte, readLowByte} == $past(per_cell_voltage_a)) else $error("bad cell");
    AST_WRITE: assert property (flashWriteEnable |-> $past(historySave))
        else $error("flash written without save");
    AST_ADDR: assert property (flashReadReq |-> flashReadAddr == 8'h28)
        else $error("wrong flash address");
endmodule
bind psc_status_word psc_status_word_asserts #(.CELL_WIDTH(CELL_WIDTH))
    psc_status_word_asserts_inst (.*);

// ===== psc_flash_model.sv
// Flash model answering the configuration read
module psc_flash_model #(
    parameter logic [7:0] CFG = 8'hC2
) (
    // Clock and request
    input wire logic clk,
    input wire logic srst,
    input wire logic flashReadReq,
    // Answer
    output logic flashReadDone,
    output logic [7:0] flashReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pipe;
    // Slow answer, three cycles after the request
    always_ff @(posedge clk) pipe <= srst ? 3'h0 : {pipe[1:0], flashReadReq};
    assign flashReadDone = pipe[2];
    // Data inverted outside done so stale values never match
    assign flashReadData = pipe[2] ? CFG : ~CFG;
endmodule

// ===== test_pack_status_config_word.sv
// Bench for the pack status and configuration word
module test_pack_status_config_word;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, readStrobe = 0, historySave = 0;
    logic [7:0] readCommand = 8'h00, readLowByte, readHighByte, flashReadAddr, flashReadData;
    logic readValid, readUnknown, flashReadReq, flashReadDone, configLoaded, flashWriteEnable;
    logic front_end_integrity_fail = 0, end_discharge_threshold_low = 0, sealedState = 0;
    logic discharge_qualified = 0, safety_limit_exceeded = 0;
    logic secondary_over_limit = 0, secondary_under_limit = 0;
    logic [15:0] per_cell_voltage_a = 16'h0E10, per_cell_voltage_b = 16'h0CE4;
    logic [15:0] per_cell_voltage_c = 16'h1036, per_cell_voltage_d = 16'h0BB8;
    int errors = 0, compares = 0;
    always #4 clk = ~clk;
    psc_status_word psc_status_word_inst (.*);
    psc_flash_model psc_flash_model_inst (.*);
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [17:0] s, input logic [17:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH read word expected %h seen %h", e, s);
        end
    endtask
    // Valid, unknown, high byte, low byte compared together
    task automatic rd(input logic [7:0] c, input logic [17:0] e);
        @(posedge clk);
        readStrobe <= 1'b1;
        readCommand <= c;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 chk({readValid, readUnknown, readHighByte, readLowByte}, e);
    endtask
    task automatic setf(input logic [6:0] f);
        @(posedge clk);
        {front_end_integrity_fail, end_discharge_threshold_low, sealedState,
            discharge_qualified, safety_limit_exceeded, secondary_over_limit,
            secondary_under_limit} <= f;
    endtask
    // Reset, then bounded wait for the configuration load
    task automatic boot();
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 20 && !configLoaded; i++) @(posedge clk);
        chk({17'h0_0000, configLoaded}, 18'h0_0001);
        chk({10'h000, flashReadAddr}, 18'h0_0028);
    endtask
    initial begin
        boot();
        setf(7'h52);
        rd(8'h2F, {2'h2, 16'hC2A2});
        @(posedge clk);
        historySave <= 1'b1;
        @(posedge clk);
        historySave <= 1'b0;
        #1 chk({17'h0_0000, flashWriteEnable}, 18'h0_0001);
        @(posedge clk);
        #1 chk({17'h0_0000, flashWriteEnable}, 18'h0_0000);
        $display("status test done");
        setf(7'h2D);
        setf(7'h29);
        rd(8'h2F, {2'h2, 16'hC255});
        $display("sticky test done");
        rd(8'h3C, {2'h2, per_cell_voltage_a});
        rd(8'h3D, {2'h2, per_cell_voltage_b});
        rd(8'h3E, {2'h2, per_cell_voltage_c});
        rd(8'h3F, {2'h2, per_cell_voltage_d});
        rd(8'h30, {2'h3, 16'h0000});
        $display("cell test done");
        boot();
        rd(8'h2F, {2'h2, 16'hC251});
        $display("reset test done");
        complete_run();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (500) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
